// File: design/msw_pkg.sv
// Package for the meter status word bank: offsets, bit positions, carriers
package msw_pkg;

  // Register addresses within the meter register map
  localparam logic [15:0] MSW_EVENT_ADDR = 16'h0fd0;
  localparam logic [15:0] MSW_ALARM_ADDR = 16'h0fd1;

  // Event word bit positions
  localparam int MSW_BIT_MEM_COMM = 12;
  localparam int MSW_BIT_NO_MEAS = 9;
  localparam int MSW_BIT_BOARD_FIT = 7;
  localparam int MSW_BIT_BOARD_ERR = 6;
  localparam int MSW_BIT_CHAR_BAD = 3;

  // Alarm word field positions
  localparam int MSW_RELAY_LSB = 0;
  localparam int MSW_LAMP_LSB = 4;
  localparam int MSW_ALARM_CNT = 4;

  // Event bits 12, 9, 7, 6 and 3; every other bit reads zero and ignores writes
  localparam logic [15:0] MSW_EVENT_MASK = 16'h12c8;

  // Values after reset
  localparam logic [15:0] MSW_EVENT_RESET = 16'h0000;
  localparam logic [15:0] MSW_ALARM_RESET = 16'h0000;

  // Event sources raised by the meter core, one-cycle or level
  typedef struct packed {
    logic mem_comm_fail;
    logic no_meas_values;
    logic board_fitted;
    logic board_error;
    logic char_invalid;
  } msw_events_t;

  // Register access request from the serial register interface
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } msw_req_t;

endpackage

// File: design/msw_status_bank.sv
// Meter status word bank: latched event word and mirrored alarm word
// Behaviour
// - An event bit reads one once its event occurred, zero otherwise.
// - Bit 12 of the event word flags data-memory communication failure.
// - Bit 9 of the event word flags no stored measured values.
// - Bit 7 of the event word flags a fitted output board.
// - Bit 6 flags output board error or missing calibration.
// - Bit 3 flags an invalid user-defined transfer characteristic.
// - Alarm word bits 4..7 mirror alarm lamps one to four.
// - Alarm word bits 0..3 mirror alarm relays one to four.
`timescale 1ns/10ps
module msw_status_bank #(
  // Alarm channels, each with one lamp and one relay
  parameter int ALARMS = msw_pkg::MSW_ALARM_CNT
) (
  // Clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Register request from the serial interface, same clock
  input wire msw_pkg::msw_req_t req_i,
  // Event sources from the meter core, same clock
  input wire msw_pkg::msw_events_t events_i,
  // Alarm lamps and relays, straight from pins
  input wire logic [ALARMS-1:0] alarm_lamp_i,
  input wire logic [ALARMS-1:0] alarm_relay_i,
  // Read answer
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // Live copies of both words
  output logic [15:0] event_fault_word_o,
  output logic [15:0] alarm_state_word_o
);
  import msw_pkg::*;

  // Overview of the bank
  // Event word: sticky flags, raised by the core, dropped only by a write.
  // Alarm word: plain mirror of the synchronised lamp and relay pins.
  // A read answers one enabled edge later with the word as it stood before.
  // Limitation: the alarm word lags its pins by three enabled edges.
  // Limitation: a level event keeps its bit set for as long as it is high.

  // Every register on the serial map is one word wide
  localparam int WORD_W = 16;
  // Upper byte of the alarm word has no source and reads zero
  localparam logic [WORD_W-1:0] ALARM_MASK = 16'h00ff;

  // Whole bank state in one record, registered together
  typedef struct packed {
    logic [WORD_W-1:0] event_word;
    logic [WORD_W-1:0] alarm_word;
    logic [WORD_W-1:0] rdata;
    logic rvalid;
  } msw_state_t;

  // One request reduced to the few facts the bank acts on
  typedef struct packed {
    logic rd;
    logic wr;
    logic event_hit;
    logic alarm_hit;
  } msw_decode_t;

  msw_state_t state_reg;
  msw_state_t state_next;
  msw_decode_t dec;
  logic [ALARMS-1:0] lamp_sync;
  logic [ALARMS-1:0] relay_sync;
  logic [WORD_W-1:0] event_set;
  logic [WORD_W-1:0] alarm_live;
  logic [WORD_W-1:0] clear_keep;
  logic [WORD_W-1:0] event_merged;
  logic [WORD_W-1:0] read_word;

  // Address compare for the event word
  // Shared by the write decode and the read mux
  function automatic logic is_event_addr(input logic [15:0] addr);
    return addr == MSW_EVENT_ADDR;
  endfunction

  // Address compare for the alarm word
  // Shared by the write decode and the read mux
  function automatic logic is_alarm_addr(input logic [15:0] addr);
    return addr == MSW_ALARM_ADDR;
  endfunction

  // Read mux; unmapped addresses answer zero rather than stall the master
  // Zero is also what unused bits show, so no separate error path
  function automatic logic [WORD_W-1:0] pick_word(
    input logic [15:0] addr,
    input logic [WORD_W-1:0] ev_word,
    input logic [WORD_W-1:0] al_word
  );
    logic [WORD_W-1:0] word;
    word = '0;
    if (is_event_addr(addr)) begin
      word = ev_word;
    end else if (is_alarm_addr(addr)) begin
      word = al_word;
    end
    return word;
  endfunction

  // Lamps and relays come from pins, so synchronise them first
  // Both groups share one synchroniser so they stay in step
  // Cost: three enabled edges from pin to register
  msw_sync #(
    .WIDTH(2 * ALARMS)
  ) u_alarm_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .async_i({alarm_lamp_i, alarm_relay_i}),
    .sync_o({lamp_sync, relay_sync})
  );

  // Request decode; both strobes share the same address compare
  // Requests are levels sampled on each enabled edge
  always_comb begin
    dec = '0;
    dec.rd = req_i.rd;
    dec.wr = req_i.wr;
    dec.event_hit = is_event_addr(req_i.addr);
    dec.alarm_hit = is_alarm_addr(req_i.addr);
  end

  // Map event sources onto their bit positions
  // Sources may be pulses or levels; both latch the same way
  always_comb begin
    event_set = '0;
    event_set[MSW_BIT_MEM_COMM] = events_i.mem_comm_fail;
    event_set[MSW_BIT_NO_MEAS] = events_i.no_meas_values;
    event_set[MSW_BIT_BOARD_FIT] = events_i.board_fitted;
    event_set[MSW_BIT_BOARD_ERR] = events_i.board_error;
    event_set[MSW_BIT_CHAR_BAD] = events_i.char_invalid;
  end

  // Per-alarm placement of lamp and relay states
  // Alarm one lands on the lowest bit of each field
  for (genvar i = 0; i < ALARMS; i++) begin : g_alarm_bit
    assign alarm_live[MSW_LAMP_LSB + i] = lamp_sync[i];
    assign alarm_live[MSW_RELAY_LSB + i] = relay_sync[i];
  end

  // Bits above the lamp field have no source
  assign alarm_live[WORD_W-1:MSW_LAMP_LSB+ALARMS] = '0;

  // Keep mask from a write: a one keeps a bit, a zero drops it
  // A master can therefore never raise a flag by writing
  // Writes to the alarm word or elsewhere leave every bit kept
  always_comb begin
    clear_keep = '1;
    if (dec.wr && dec.event_hit) begin
      clear_keep = req_i.wdata;
    end
  end

  // Set wins over a same-cycle clear so an event is never lost
  // The mask keeps unused bits at zero whatever was written
  // Hazard: a level event held high cannot be cleared until it drops
  always_comb begin
    event_merged = state_reg.event_word & clear_keep;
    event_merged = event_merged | event_set;
    event_merged = event_merged & MSW_EVENT_MASK;
  end

  // Read answers with the word as it stood before this edge
  // So a read and a write in one cycle see the old value
  assign read_word = pick_word(req_i.addr, state_reg.event_word, state_reg.alarm_word);

  // Next state; alarm word writes are dropped on purpose, it is a mirror
  // Read valid is a one-cycle pulse, read data holds until the next read
  // Every field has a value on every path through this process
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.event_word = event_merged;
    state_next.alarm_word = alarm_live & ALARM_MASK;
    if (dec.rd) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word;
    end
  end

  // State register; low enable holds everything including read data
  // Reset loads constants only
  // Both words read zero until the first enabled edge after reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg.event_word <= MSW_EVENT_RESET;
      state_reg.alarm_word <= MSW_ALARM_RESET;
      state_reg.rdata <= '0;
      state_reg.rvalid <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  // No logic after the register, so the ports never glitch
  assign rdata_o = state_reg.rdata;
  assign rvalid_o = state_reg.rvalid;
  assign event_fault_word_o = state_reg.event_word;
  assign alarm_state_word_o = state_reg.alarm_word;

endmodule

// File: design/msw_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
module msw_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } msw_sync_state_t;

  msw_sync_state_t state_reg;
  msw_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = async_i;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stage2;

endmodule

// File: verif/msw_master.sv
// Remote master model issuing one register request per call
`timescale 1ns/10ps
module msw_master (
  input wire logic clk_sys_i,
  output msw_pkg::msw_req_t req_o
);
  import msw_pkg::*;
  initial req_o = '0;
  // Held over one rising edge, then dropped with address and data flipped
  task automatic xfer(input logic r, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_i) req_o = {r, !r, a, d};
    @(negedge clk_sys_i) req_o = {2'b00, ~a, ~d};
  endtask
endmodule

// File: verif/msw_monitor.sv
// Assertion checker for the status word bank
`timescale 1ns/10ps
module msw_monitor #(parameter int ALARMS = 4) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire msw_pkg::msw_req_t req_i,
  input wire msw_pkg::msw_events_t events_i,
  input wire logic [ALARMS-1:0] alarm_lamp_i,
  input wire logic [ALARMS-1:0] alarm_relay_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [15:0] event_fault_word_o,
  input wire logic [15:0] alarm_state_word_o
);
  import msw_pkg::*;
  logic [15:0] w, a, ev;
  logic wr;
  // Short names; event sources placed at their word bits
  assign w = event_fault_word_o;
  assign a = alarm_state_word_o;
  assign ev = {3'h0,events_i[4],2'h0,events_i[3],1'h0,events_i[2:1],2'h0,events_i[0],3'h0};
  assign wr = ce_i && req_i.wr && req_i.addr == MSW_EVENT_ADDR;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_event_set: assert property (ce_i |=> &(w | ~$past(ev)))
    else $error("event not latched");
  chk_event_hold: assert property (ce_i && !wr |=> w == ($past(w) | $past(ev)))
    else $error("event word moved");
  chk_clear_only: assert property (wr |=> w == ($past(w) & $past(req_i.wdata) | $past(ev)))
    else $error("write set a bit");
  chk_unused_zero: assert property ((w & ~MSW_EVENT_MASK) == 16'h0 && a[15:8] == 8'h0)
    else $error("unused bit set");
  chk_lamp_map: assert property (($stable(alarm_lamp_i) && ce_i)[*4]
    |-> a[7:4] == alarm_lamp_i) else $error("lamp bit wrong");
  chk_relay_map: assert property (($stable(alarm_relay_i) && ce_i)[*4]
    |-> a[3:0] == alarm_relay_i) else $error("relay bit wrong");
  chk_read_event: assert property (ce_i && req_i.rd && req_i.addr == MSW_EVENT_ADDR
    |=> rvalid_o && rdata_o == $past(w)) else $error("bad event read");
  chk_read_alarm: assert property (ce_i && req_i.rd && req_i.addr == MSW_ALARM_ADDR
    |=> rvalid_o && rdata_o == $past(a)) else $error("bad alarm read");
  chk_rvalid_pulse: assert property (ce_i && !req_i.rd |=> !rvalid_o)
    else $error("stray read valid");
endmodule
bind msw_status_bank msw_monitor #(.ALARMS(ALARMS)) mon (.*);

// File: verif/tb.sv
// Self-checking bench for the status word bank
`timescale 1ns/10ps
module tb;
  import msw_pkg::*;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, rvalid_o;
  logic [3:0] alarm_lamp_i = 4'h0, alarm_relay_i = 4'h0;
  logic [15:0] rdata_o, event_fault_word_o, alarm_state_word_o;
  msw_req_t req_i;
  msw_events_t events_i = '0;
  int n_errors = 0, total_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  msw_master m (.clk_sys_i(clk_sys_i), .req_o(req_i));
  msw_status_bank dut (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .req_i(req_i),
    .events_i(events_i),
    .alarm_lamp_i(alarm_lamp_i),
    .alarm_relay_i(alarm_relay_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .event_fault_word_o(event_fault_word_o),
    .alarm_state_word_o(alarm_state_word_o)
  );
  // Count every compare, report a mismatch at once
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) n_errors++;
    if (g !== e) $display("Error %s exp %h got %h", s, e, g);
  endtask
  task automatic t_events();
    int p[5] = '{12, 9, 7, 6, 3};
    logic [15:0] e = 16'h0;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys_i) events_i = msw_events_t'(5'h10 >> i);
      @(negedge clk_sys_i) events_i = '0;
      e[p[i]] = 1'b1;
      chk("event word", e, event_fault_word_o);
    end
    m.xfer(1'b1, MSW_EVENT_ADDR, 16'h0);
    chk("event read", 16'h12c8, rdata_o);
    chk("read valid", 16'h0001, {15'h0, rvalid_o});
    $display("events done");
  endtask
  // Writes only clear; a live event wins over the clear
  task automatic t_clear();
    m.xfer(1'b0, MSW_EVENT_ADDR, 16'hefff);
    chk("clear", 16'h02c8, event_fault_word_o);
    m.xfer(1'b0, MSW_EVENT_ADDR, 16'hffff);
    chk("no set", 16'h02c8, event_fault_word_o);
    events_i.board_fitted = 1'b1;
    m.xfer(1'b0, MSW_EVENT_ADDR, 16'h0);
    chk("set wins", 16'h0080, event_fault_word_o);
    $display("clear done");
  endtask
  // Pins need three edges; the write to the alarm word must be ignored
  task automatic t_alarm();
    alarm_lamp_i = 4'ha;
    alarm_relay_i = 4'h5;
    m.xfer(1'b0, MSW_ALARM_ADDR, 16'h0);
    m.xfer(1'b1, MSW_ALARM_ADDR, 16'h0);
    chk("alarm read", 16'h00a5, rdata_o);
    chk("alarm word", 16'h00a5, alarm_state_word_o);
    m.xfer(1'b1, 16'h0fd2, 16'h0);
    chk("unmapped", 16'h0, rdata_o);
    $display("alarm done");
  endtask
  // Low enable freezes the words even while an event is raised
  task automatic t_freeze();
    @(negedge clk_sys_i) ce_i = 1'b0;
    events_i.mem_comm_fail = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("frozen", 16'h0080, event_fault_word_o);
    ce_i = 1'b1;
    @(negedge clk_sys_i) events_i.mem_comm_fail = 1'b0;
    chk("thawed", 16'h1080, event_fault_word_o);
    $display("freeze done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    t_events();
    t_clear();
    t_alarm();
    t_freeze();
    complete_run();
  end
endmodule
